// >>> swrl_pkg.sv
// Purpose: Shared constants and types for the single-wire register link.
// Assumes: One device clock; positions count bit periods after the
//          middle start bit, the third start bit being position 0.
// Notes:   Register file, status register and interrupt source sit outside.
package swrl_pkg;

  // Bit-period measurement range in device clock cycles
  localparam int unsigned SWRL_MAX_BIT_CYCLES   = 1024;
  localparam int unsigned SWRL_CNT_W            = 11;

  // Interrupt pulse on the shared line
  localparam int unsigned SWRL_CLK_PERIOD_NS    = 4;
  localparam int unsigned SWRL_INT_PULSE_NS     = 2000;
  localparam int unsigned SWRL_INT_PULSE_CYCLES =
    (SWRL_INT_PULSE_NS / SWRL_CLK_PERIOD_NS < 1) ? 1 :
    SWRL_INT_PULSE_NS / SWRL_CLK_PERIOD_NS;
  localparam int unsigned SWRL_INT_CNT_W        = 12;

  // Operation codes, first received bit in the MSB
  localparam logic [2:0] SWRL_OP_READ  = 3'h6;
  localparam logic [2:0] SWRL_OP_WRITE = 3'h3;

  // Bit positions within a stream
  localparam logic [4:0] SWRL_POS_OP_FIRST   = 5'h01;
  localparam logic [4:0] SWRL_POS_OP_LAST    = 5'h03;
  localparam logic [4:0] SWRL_POS_ADDR_FIRST = 5'h04;
  localparam logic [4:0] SWRL_POS_ADDR_LAST  = 5'h08;
  localparam logic [4:0] SWRL_POS_DATA_FIRST = 5'h0A;
  localparam logic [4:0] SWRL_POS_DATA_LAST  = 5'h11;
  localparam logic [4:0] SWRL_POS_PAR0       = 5'h12;
  localparam logic [4:0] SWRL_POS_PAR1       = 5'h13;
  localparam logic [4:0] SWRL_POS_ACK0       = 5'h15;
  localparam logic [4:0] SWRL_POS_ACK1       = 5'h16;
  localparam logic [4:0] SWRL_POS_READ_END   = 5'h15;
  localparam logic [4:0] SWRL_POS_WRITE_END  = 5'h18;

  // Status register holding the serial parity error flag
  localparam logic [4:0] SWRL_STATUS_ADDR    = 5'h1A;
  localparam int unsigned SWRL_PARITY_ERR_BIT = 2;

  typedef enum logic [1:0] {
    SWRL_IDLE    = 2'b00,
    SWRL_LEAD    = 2'b01,
    SWRL_MEASURE = 2'b11,
    SWRL_FRAME   = 2'b10
  } swrl_state_e;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [4:0] addr;
    logic [7:0] wdata;
  } swrl_reg_req_s;

endpackage

// >>> swrl_bit_timer.sv
// Purpose: Measures one bit period and then ticks bit middles and ends.
// Assumes: clear and latch are single-cycle pulses from the link logic.
// Notes:   Period equals edge-to-edge cycles of the measured bit.
`timescale 1ns/1ps
module swrl_bit_timer
  import swrl_pkg::*;
#(
  parameter int unsigned CNT_W = SWRL_CNT_W
) (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic clear,
  input  wire logic latch,
  output logic      mid_tick,
  output logic      bit_tick,
  output logic      overflow
);

  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] period;
  logic             run;

  wire [CNT_W-1:0] cnt_inc  = cnt + 1'b1;
  wire [CNT_W-1:0] last_cnt = period - 1'b1;
  wire [CNT_W-1:0] half_cnt = period >> 1;

  assign bit_tick = run && (cnt == last_cnt);
  assign mid_tick = run && (cnt == half_cnt);
  assign overflow = !run && (cnt >= CNT_W'(SWRL_MAX_BIT_CYCLES));

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt    <= '0;
      period <= '0;
      run    <= 1'b0;
    end else if (ce) begin
      if (clear) begin
        cnt <= '0;
        run <= 1'b0;
      end else if (latch) begin
        period <= cnt_inc;
        cnt    <= '0;
        run    <= 1'b1;
      end else if (bit_tick) begin
        cnt <= '0;
      end else if (!overflow) begin
        cnt <= cnt_inc;
      end
    end
  end

endmodule // swrl_bit_timer

// >>> swrl_link.sv
// Purpose: Device end of the single-wire register link and interrupt pin.
// Assumes: Pin and register inputs are synchronous to clock; reg_rdata is
//          valid one cycle after a read request.
// Notes:   clock is the device clock input that the host times against.
`timescale 1ns/1ps
module swrl_link
  import swrl_pkg::*;
#(
  parameter int unsigned CNT_W = SWRL_CNT_W
) (
  input  wire logic    clock,
  input  wire logic    rst_n,
  input  wire logic    ce,
  input  wire logic    line_in,
  input  wire logic    int_polarity,
  input  wire logic    int_pending,
  input  wire logic [7:0] reg_rdata,
  output logic         line_out,
  output logic         line_oe_n,
  output swrl_reg_req_s reg_req,
  output logic [7:0]   status_set
);

  swrl_state_e   state;
  swrl_state_e   next_state;
  logic          line_d;
  logic [4:0]    pos;
  logic [2:0]    op;
  logic [4:0]    addr;
  logic [7:0]    data;
  logic [1:0]    par;
  logic          is_read;
  logic          ack_ok;
  logic          rd_wait;
  logic          int_prev;
  logic          int_arm;
  logic [SWRL_INT_CNT_W-1:0] int_cnt;

  logic          mid_tick;
  logic          bit_tick;
  logic          overflow;

  // Line levels: the line rests at the inactive interrupt level
  wire idle_lvl  = ~int_polarity;
  wire edge_seen = line_in != line_d;
  wire lead_seen = line_oe_n && (line_d == idle_lvl) &&
                   (line_in != idle_lvl);

  wire in_idle    = state == SWRL_IDLE;
  wire in_lead    = state == SWRL_LEAD;
  wire in_measure = state == SWRL_MEASURE;
  wire in_frame   = state == SWRL_FRAME;

  // Middle start bit runs from the edge that ends the lead bit to the next edge
  wire tm_clear = (in_idle && lead_seen) || (in_lead && edge_seen);
  wire tm_latch = in_measure && edge_seen;
  wire too_long = (in_lead || in_measure) && overflow;

  // Field decode on bit middles and ends
  wire op_ok     = (op == SWRL_OP_READ) || (op == SWRL_OP_WRITE);
  wire op_end    = in_frame && bit_tick && (pos == SWRL_POS_OP_LAST);
  wire op_bad    = op_end && !op_ok;
  wire addr_end  = in_frame && bit_tick && (pos == SWRL_POS_ADDR_LAST);
  wire par_end   = in_frame && bit_tick && (pos == SWRL_POS_PAR1);
  wire [4:0] end_pos = is_read ? SWRL_POS_READ_END : SWRL_POS_WRITE_END;
  wire frame_end = in_frame && bit_tick && (pos == end_pos);

  wire smp_op   = (pos >= SWRL_POS_OP_FIRST) && (pos <= SWRL_POS_OP_LAST);
  wire smp_addr = (pos >= SWRL_POS_ADDR_FIRST) &&
                  (pos <= SWRL_POS_ADDR_LAST);
  wire smp_data = !is_read && (pos >= SWRL_POS_DATA_FIRST) &&
                  (pos <= SWRL_POS_DATA_LAST);
  wire sample   = in_frame && mid_tick;

  // Parity over code, address and data
  wire par_calc = ^{op, addr, data};
  wire par_good = (par[0] == par_calc) && (par[1] == ~par[0]);
  wire wr_good  = par_end && !is_read && par_good;
  wire wr_fail  = par_end && !is_read && !par_good;

  // Drive decision for the bit that starts at this boundary
  wire [4:0] next_pos = pos + 5'h01;
  wire [4:0] dix      = next_pos - SWRL_POS_DATA_FIRST;
  wire rd_drive = is_read && (next_pos >= SWRL_POS_DATA_FIRST) &&
                  (next_pos <= SWRL_POS_PAR1);
  wire rd_bit   = (next_pos == SWRL_POS_PAR0) ? par_calc :
                  (next_pos == SWRL_POS_PAR1) ? ~par_calc :
                  data[dix[2:0]];
  wire ack_drive = !is_read && ack_ok &&
                   ((next_pos == SWRL_POS_ACK0) ||
                    (next_pos == SWRL_POS_ACK1));
  wire ack_bit   = (next_pos == SWRL_POS_ACK0) ? par[0] : par[1];
  wire frm_drive = !frame_end && (rd_drive || ack_drive);
  wire frm_bit   = rd_drive ? rd_bit : ack_bit;

  // Interrupt shares the pin, pulsed only between streams
  wire int_set  = (int_pending && !int_prev) ||
                  (frame_end && int_pending);
  wire int_fire = in_idle && int_arm && int_pending &&
                  (int_cnt == '0) && !lead_seen;
  wire int_drive = in_idle && (int_cnt != '0);
  wire next_arm  = int_pending && (int_set || (int_arm && !int_fire));
  // The firing cycle drives too, so the count loads one short
  wire [SWRL_INT_CNT_W-1:0] next_int_cnt =
    int_fire ? SWRL_INT_CNT_W'(SWRL_INT_PULSE_CYCLES - 1) :
    int_drive ? int_cnt - 1'b1 : '0;

  wire next_oe_n =
    in_frame ? (bit_tick ? !frm_drive : line_oe_n) :
    !(int_drive || int_fire);
  wire next_out =
    in_frame ? (bit_tick ? (frm_drive && frm_bit) : line_out) :
    ((int_drive || int_fire) ? int_polarity : 1'b0);

  // Register requests pulse for one cycle
  swrl_reg_req_s next_req;
  assign next_req.wr    = wr_good;
  assign next_req.rd    = addr_end && (op == SWRL_OP_READ);
  assign next_req.addr  = addr;
  assign next_req.wdata = data;

  wire [7:0] next_status =
    wr_fail ? (8'h01 << SWRL_PARITY_ERR_BIT) : 8'h00;

  always_comb begin
    next_state = state;
    unique case (state)
      SWRL_IDLE:    if (lead_seen) next_state = SWRL_LEAD;
      SWRL_LEAD: begin
        if (too_long) next_state = SWRL_IDLE;
        else if (edge_seen) next_state = SWRL_MEASURE;
      end
      SWRL_MEASURE: begin
        if (too_long) next_state = SWRL_IDLE;
        else if (edge_seen) next_state = SWRL_FRAME;
      end
      SWRL_FRAME: begin
        if (op_bad || frame_end) next_state = SWRL_IDLE;
      end
    endcase
  end

  swrl_bit_timer #(
    .CNT_W    (CNT_W)
  ) u_timer (
    .clock    (clock),
    .rst_n    (rst_n),
    .ce       (ce),
    .clear    (tm_clear),
    .latch    (tm_latch),
    .mid_tick (mid_tick),
    .bit_tick (bit_tick),
    .overflow (overflow)
  );

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= SWRL_IDLE;
      pos   <= 5'h00;
    end else if (ce) begin
      state <= next_state;
      if (!in_frame) pos <= 5'h00;
      else if (bit_tick) pos <= next_pos;
    end
  end

  // Field capture at bit middles; guard and start levels are dropped
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      op   <= 3'h0;
      addr <= 5'h00;
      par  <= 2'h0;
    end else if (ce && sample) begin
      if (smp_op) op <= {op[1:0], line_in};
      if (smp_addr) addr <= {line_in, addr[4:1]};
      if (pos == SWRL_POS_PAR0) par[0] <= line_in;
      if (pos == SWRL_POS_PAR1) par[1] <= line_in;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      data <= 8'h00;
    end else if (ce) begin
      if (rd_wait) data <= reg_rdata;
      else if (sample && smp_data) data <= {line_in, data[7:1]};
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      is_read <= 1'b0;
      ack_ok  <= 1'b0;
      rd_wait <= 1'b0;
    end else if (ce) begin
      // Register file answers one cycle after it sees the read pulse
      rd_wait <= reg_req.rd;
      if (tm_latch) is_read <= 1'b0;
      else if (op_end) is_read <= op == SWRL_OP_READ;
      if (tm_latch) ack_ok <= 1'b0;
      else if (par_end) ack_ok <= wr_good;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      line_d   <= 1'b1;
      int_prev <= 1'b0;
      int_arm  <= 1'b0;
      int_cnt  <= '0;
    end else if (ce) begin
      line_d   <= line_in;
      int_prev <= int_pending;
      int_arm  <= next_arm;
      int_cnt  <= next_int_cnt;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      line_out   <= 1'b0;
      line_oe_n  <= 1'b1;
      reg_req    <= '0;
      status_set <= 8'h00;
    end else if (ce) begin
      line_out   <= next_out;
      line_oe_n  <= next_oe_n;
      reg_req    <= next_req;
      status_set <= next_status;
    end
  end

endmodule // swrl_link

// >>> swrl_link_assertions.sv
// Purpose: Port checks for the single-wire register link.
// Assumes: Bound to each swrl_link.
// Notes:   Quiet span exceeds a full read stream but is shorter than a full write stream.
`timescale 1ns/1ps
module swrl_link_assertions
  import swrl_pkg::*;
#(
  parameter int unsigned CNT_W = SWRL_CNT_W
) (
  input wire logic          clock,
  input wire logic          rst_n,
  input wire logic          ce,
  input wire logic          line_in,
  input wire logic          int_polarity,
  input wire logic          int_pending,
  input wire logic [7:0]    reg_rdata,
  input wire logic          line_out,
  input wire logic          line_oe_n,
  input wire swrl_reg_req_s reg_req,
  input wire logic [7:0]    status_set
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic [14:0] quiet;

  // Cycles with nothing pending and the wire idle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n)
      quiet <= '0;
    else if (int_pending || line_in == int_polarity || !line_oe_n)
      quiet <= '0;
    else if (quiet != 15'h7FFF)
      quiet <= quiet + 15'h0001;
  end

  chk_released_low: assert property (line_oe_n |-> !line_out)
    else $error("released wire data high");
  chk_status_b2: assert property ((status_set & 8'hFB) == 8'h00)
    else $error("stray status bit");
  chk_req_excl: assert property (!(reg_req.wr && reg_req.rd))
    else $error("read and write together");
  chk_wr_single: assert property (reg_req.wr |=> !reg_req.wr)
    else $error("write pulse too long");
  chk_rd_single: assert property ($rose(reg_req.rd) |=> !reg_req.rd [*2])
    else $error("read pulse repeated");
  chk_err_no_wr: assert property (status_set[2] |-> !reg_req.wr ##1 !reg_req.wr)
    else $error("write on parity error");
  chk_quiet_hold: assert property (quiet >= 15'h6590 |-> line_oe_n)
    else $error("device drove unprompted");
  chk_reset_quiet: assert property ($rose(rst_n) |-> line_oe_n [*2])
    else $error("drive right after reset");
  chk_bit_stands: assert property (!line_oe_n && ($fell(line_oe_n) ||
    $changed(line_out)) |=> (line_oe_n || $stable(line_out)) [*3])
    else $error("driven bit too short");
endmodule // swrl_link_assertions

bind swrl_link swrl_link_assertions #(.CNT_W(CNT_W)) i_chk (
  .clock(clock), .rst_n(rst_n), .ce(ce), .line_in(line_in),
  .int_polarity(int_polarity), .int_pending(int_pending),
  .reg_rdata(reg_rdata), .line_out(line_out), .line_oe_n(line_oe_n),
  .reg_req(reg_req), .status_set(status_set));

// >>> swrl_host.sv
// Purpose: Host end of the link, driving register streams.
// Assumes: xfer is entered at a falling clock edge.
// Notes:   Device bits sampled one cycle before slot end.
`timescale 1ns/1ps
module swrl_host
  import swrl_pkg::*;
(
  input  wire logic clock,
  input  wire logic pol,
  input  wire logic line,
  output logic      h_out,
  output logic      h_oe_n
);
  initial begin
    h_out = 1'h0;
    h_oe_n = 1'h1;
  end

  // Slot k is bit position k-2; guards leave the wire released
  task automatic xfer(input logic [2:0] op, input logic [4:0] a,
      input logic [7:0] d, input logic bad, input int t,
      output logic [7:0] q, output logic [1:0] pb);
    logic [21:0] hv;
    logic        rdp;
    int          n;
    int          base;
    rdp = (op == SWRL_OP_READ);
    hv = {~(^{op, a, d} ^ bad), ^{op, a, d} ^ bad, d, 1'h0, a,
          op[0], op[1], op[2], pol, ~pol, pol};
    n = rdp ? 24 : (op == SWRL_OP_WRITE) ? 27 : 6;
    base = rdp ? 20 : 23;
    q = 8'h00;
    pb = 2'h0;
    for (int k = 0; k < n; k++) begin
      h_oe_n = !(k < 11 || (!rdp && k > 11 && k < 22));
      h_out = !h_oe_n && hv[k];
      repeat (t - 1) @(negedge clock);
      if (k >= 12 && k < 20) q[k - 12] = line;
      if (k == base || k == base + 1) pb[k - base] = line;
      @(negedge clock);
    end
    h_oe_n = 1'h1;
    h_out = 1'h0;
  endtask
endmodule // swrl_host

// >>> swrl_link_tb.sv
// Purpose: Self-checking bench for the single-wire register link.
// Assumes: Host model drives streams; an array answers register requests.
// Notes:   Random fields come from an LFSR with a fixed seed.
`timescale 1ns/1ps
module swrl_link_tb;
  import swrl_pkg::*;
`define CHK(a, b, m) begin num_checks++; if ((a) !== (b)) begin \
  errors++; $display("[FAIL] %0t %s", $time, m); end end
  logic          clock;
  logic          rst_n = 1'h0;
  logic          ce = 1'h1;
  logic          pol = 1'h0;
  logic          pend = 1'h0;
  logic [7:0]    rdata = 8'h00;
  logic          line_out;
  logic          oe_n;
  swrl_reg_req_s req;
  logic [7:0]    status_set;
  logic          h_out;
  logic          h_oe_n;
  wire           line;
  logic [7:0]    mem [32];
  logic [15:0]   seed = 16'h881B;
  int            errors = 0;
  int            num_checks = 0;
  int            wr_cnt = 0, rd_cnt = 0, err_cnt = 0, run_len = 0, last_len = 0;

  // Released wire falls to the weak pull at the inactive level
  assign line = !oe_n ? line_out : !h_oe_n ? h_out : ~pol;
  swrl_link i_dut (.clock(clock), .rst_n(rst_n), .ce(ce), .line_in(line),
    .int_polarity(pol), .int_pending(pend), .reg_rdata(rdata),
    .line_out(line_out), .line_oe_n(oe_n), .reg_req(req),
    .status_set(status_set));
  swrl_host i_host (.clock(clock), .pol(pol), .line(line), .h_out(h_out),
    .h_oe_n(h_oe_n));

  always @(posedge clock) begin
    if (req.wr === 1'h1) begin
      mem[req.addr] <= req.wdata;
      wr_cnt++;
    end
    if (req.rd === 1'h1) begin
      rdata <= mem[req.addr];
      rd_cnt++;
    end
    if (status_set[2] === 1'h1) err_cnt++;
    if (oe_n === 1'h0) run_len++;
    else if (run_len != 0) begin
      last_len = run_len;
      run_len = 0;
    end
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic par(input logic [2:0] op, input logic [4:0] a,
      input logic [7:0] d);
    return ^{op, a, d};
  endfunction

  task automatic run(input logic [2:0] op, input logic [4:0] a,
      input logic [7:0] d, input logic bad, input int t);
    logic [7:0] q;
    logic [1:0] pb;
    logic [7:0] x;
    logic       p;
    int         w;
    int         r;
    for (int i = 0; i < 1200 && oe_n !== 1'h1; i++) @(negedge clock);
    repeat (2) @(negedge clock);
    w = wr_cnt + err_cnt;
    r = rd_cnt;
    x = mem[a];
    p = par(op, a, op == SWRL_OP_READ ? x : d);
    i_host.xfer(op, a, d, bad, t, q, pb);
    repeat (3) @(negedge clock);
    if (op == SWRL_OP_WRITE) begin
      `CHK(wr_cnt + err_cnt, w + 1, "write outcome");
      `CHK(mem[a], bad ? x : d, "stored data");
      `CHK(pb, bad ? {2{~pol}} : {~p, p}, "ack bits");
    end else if (op == SWRL_OP_READ) begin
      `CHK(q, x, "read data");
      `CHK(pb, {~p, p}, "read parity");
      `CHK(rd_cnt, r + 1, "read count");
    end else
      `CHK(wr_cnt + err_cnt + rd_cnt, w + r, "bad code access");
  endtask

  task automatic expect_pulse;
    last_len = 0;
    for (int i = 0; i < 2000 && last_len == 0; i++) begin
      @(negedge clock);
      if (oe_n === 1'h0) `CHK(line_out, pol, "int level");
    end
    `CHK(last_len, SWRL_INT_PULSE_CYCLES, "int pulse");
  endtask

  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    clock = 1'h0;
    forever #2 clock = ~clock;
  end

  initial begin
    #380000;
    errors++;
    wrap_up;
  end

  initial begin
    for (int i = 0; i < 32; i++) begin
      seed = lfsr(seed);
      mem[i] = seed[7:0];
    end
    for (int pi = 0; pi < 2; pi++) begin
      rst_n = 1'h0;
      pend = 1'h0;
      pol = pi[0];
      repeat (6) @(negedge clock);
      rst_n = 1'h1;
      repeat (3) @(negedge clock);
      `CHK(oe_n, 1'h1, "released after reset");
      run(SWRL_OP_WRITE, 5'h1F, 8'hA5, 1'h0, 6);
      run(SWRL_OP_READ, 5'h1F, 8'h00, 1'h0, 6);
      run(SWRL_OP_WRITE, 5'h00, 8'hFF, 1'h1, 9);
      for (int c = 0; c < 8; c++)
        if (c != 3 && c != 6) run(c[2:0], 5'h05, 8'h5A, 1'h0, 7);
      for (int k = 0; k < 8; k++) begin
        seed = lfsr(seed);
        run(seed[0] ? SWRL_OP_READ : SWRL_OP_WRITE, seed[5:1], seed[13:6],
            seed[15] & seed[14], 6 + int'(seed[11:6]));
      end
      pend = 1'h1;
      expect_pulse();
      run(SWRL_OP_READ, 5'h1F, 8'h00, 1'h0, 8);
      expect_pulse();
      pend = 1'h0;
    end
    run(SWRL_OP_WRITE, 5'h0A, 8'h3C, 1'h0, 1024);
    repeat (26100) @(negedge clock);
    wrap_up;
  end
endmodule // swrl_link_tb
